// *** prl_core.sv ***
// macrocell output registers with power-up clear, pin preload and design lock
// assumes the array drives sop_in, oe_term and the two terms on this clock;
// clock pins and pin readback arrive from outside and are synchronised here
`timescale 1ns/1ps
`include "prl_defs.svh"

module prl_core (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port
  input wire prl_pkg::prl_bus_t bus,
  output logic [`PRL_DW-1:0] rdata,
  // array terms
  input wire logic [`PRL_NCELL-1:0] sop_in,
  input wire logic [`PRL_NCELL-1:0] oe_term,
  input wire logic sync_set_term,
  input wire logic async_clear_term,
  // clock pins and macrocell pins
  input wire logic clk_a_pin,
  input wire logic clk_b_pin,
  input wire logic [`PRL_NCELL-1:0] pin_in,
  output prl_pkg::prl_pins_t pins,
  // state
  output logic ready
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one is read only by stage two
  logic clk_a_s1, clk_a_s2, clk_a_s3;
  logic clk_b_s1, clk_b_s2, clk_b_s3;
  logic [`PRL_NCELL-1:0] pin_s1, pin_s2;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clk_a_s1 <= 1'b0;
      clk_a_s2 <= 1'b0;
      clk_a_s3 <= 1'b0;
      clk_b_s1 <= 1'b0;
      clk_b_s2 <= 1'b0;
      clk_b_s3 <= 1'b0;
      pin_s1 <= 12'h000;
      pin_s2 <= 12'h000;
    end else begin
      clk_a_s1 <= clk_a_pin;
      clk_a_s2 <= clk_a_s1;
      clk_a_s3 <= clk_a_s2;
      clk_b_s1 <= clk_b_pin;
      clk_b_s2 <= clk_b_s1;
      clk_b_s3 <= clk_b_s2;
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  logic edge_a, edge_b;
  assign edge_a = clk_a_s2 & ~clk_a_s3;
  assign edge_b = clk_b_s2 & ~clk_b_s3;

  ////////////////////////////////////////////////////////////////////////////
  // control state, configuration and pattern store
  prl_pkg::prl_state_t state, next_state;
  logic [7:0] por_cnt, next_por_cnt;
  logic preload_mode, next_preload_mode;
  logic secure, next_secure;
  logic [`PRL_NCELL-1:0] polarity, next_polarity;
  logic [`PRL_NCELL-1:0] clksel, next_clksel;
  logic [`PRL_NCELL-1:0] bypass, next_bypass;
  logic [`PRL_PAT_IW-1:0] pat_index, next_pat_index;
  logic [`PRL_DW-1:0] pattern [`PRL_PAT_DEPTH];
  logic [`PRL_DW-1:0] next_pattern [`PRL_PAT_DEPTH];
  logic [`PRL_DW-1:0] next_rdata;
  logic ctrl_wr, erase_hit, preload_hit;
  logic [`PRL_NCELL-1:0] q;

  assign ctrl_wr = bus.wr && (bus.addr == `PRL_ADDR_CTRL);
  assign erase_hit = ctrl_wr && bus.wdata[`PRL_CTRL_ERASE];
  // a preload request in the same write as the lock still loads; only a lock already set blocks it
  assign preload_hit = ctrl_wr && bus.wdata[`PRL_CTRL_PRELOAD_GO] && preload_mode && !secure;

  always_comb begin
    next_state = state;
    next_por_cnt = por_cnt;
    next_preload_mode = preload_mode;
    next_secure = secure;
    next_polarity = polarity;
    next_clksel = clksel;
    next_bypass = bypass;
    next_pat_index = pat_index;
    next_pattern = pattern;
    next_rdata = 16'h0000;
    unique case (state)
      prl_pkg::PRL_POR: begin
        next_por_cnt = por_cnt + 8'h01;
        if (por_cnt == 8'(`PRL_PUR_CYCLES - 1)) begin
          next_state = prl_pkg::PRL_RUN;
        end
      end
      prl_pkg::PRL_RUN: begin
        next_por_cnt = por_cnt;
      end
    endcase
    if (erase_hit) begin
      // whole pattern goes with the lock, never the lock alone
      next_secure = 1'b0;
      next_preload_mode = 1'b0;
      next_polarity = `PRL_POL_RESET;
      next_clksel = `PRL_CLKSEL_RESET;
      next_bypass = `PRL_BYPASS_RESET;
      next_pat_index = 3'h0;
      for (int i = 0; i < `PRL_PAT_DEPTH; i++) begin
        next_pattern[i] = `PRL_PAT_RESET;
      end
    end else if (bus.wr) begin
      unique case (bus.addr)
        `PRL_ADDR_CTRL: begin
          if (bus.wdata[`PRL_CTRL_SECURE]) begin
            next_secure = 1'b1;
          end
          next_preload_mode = bus.wdata[`PRL_CTRL_PRELOAD_MODE] && !secure && !bus.wdata[`PRL_CTRL_SECURE];
        end
        `PRL_ADDR_POLARITY: if (!secure) next_polarity = bus.wdata[`PRL_NCELL-1:0];
        `PRL_ADDR_CLKSEL: if (!secure) next_clksel = bus.wdata[`PRL_NCELL-1:0];
        `PRL_ADDR_BYPASS: if (!secure) next_bypass = bus.wdata[`PRL_NCELL-1:0];
        `PRL_ADDR_PAT_INDEX: next_pat_index = bus.wdata[`PRL_PAT_IW-1:0];
        `PRL_ADDR_PAT_DATA: if (!secure) next_pattern[pat_index] = bus.wdata;
        default: next_pat_index = pat_index;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        `PRL_ADDR_CTRL: next_rdata = {15'h0000, preload_mode};
        `PRL_ADDR_STATUS: next_rdata = {13'h0000, preload_mode, secure, state == prl_pkg::PRL_RUN};
        `PRL_ADDR_STATE: next_rdata = {4'h0, q};
        // configuration hides behind the lock like the array
        `PRL_ADDR_POLARITY: next_rdata = secure ? `PRL_DISCONNECTED : {4'h0, polarity};
        `PRL_ADDR_CLKSEL: next_rdata = secure ? `PRL_DISCONNECTED : {4'h0, clksel};
        `PRL_ADDR_BYPASS: next_rdata = secure ? `PRL_DISCONNECTED : {4'h0, bypass};
        `PRL_ADDR_PAT_INDEX: next_rdata = {13'h0000, pat_index};
        `PRL_ADDR_PAT_DATA: next_rdata = secure ? `PRL_DISCONNECTED : pattern[pat_index];
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= prl_pkg::PRL_POR;
      por_cnt <= 8'h00;
      preload_mode <= 1'b0;
      secure <= 1'b0;
      polarity <= `PRL_POL_RESET;
      clksel <= `PRL_CLKSEL_RESET;
      bypass <= `PRL_BYPASS_RESET;
      pat_index <= 3'h0;
      rdata <= 16'h0000;
      for (int i = 0; i < `PRL_PAT_DEPTH; i++) begin
        pattern[i] <= `PRL_PAT_RESET;
      end
    end else begin
      state <= next_state;
      por_cnt <= next_por_cnt;
      preload_mode <= next_preload_mode;
      secure <= next_secure;
      polarity <= next_polarity;
      clksel <= next_clksel;
      bypass <= next_bypass;
      pat_index <= next_pat_index;
      rdata <= next_rdata;
      pattern <= next_pattern;
    end
  end

  assign ready = (state == prl_pkg::PRL_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // macrocell flip-flops; the clear term is a second asynchronous reset
  logic mc_clear_n;
  logic [`PRL_NCELL-1:0] next_q, cell_edge, cell_val;
  prl_pkg::prl_pins_t next_pins;

  assign mc_clear_n = resetn & ~async_clear_term;
  assign cell_edge = (clksel & {`PRL_NCELL{edge_a}}) | (~clksel & {`PRL_NCELL{edge_b}});

  always_comb begin
    next_q = q;
    if (state == prl_pkg::PRL_POR) begin
      next_q = 12'h000;
    end else if (preload_hit) begin
      next_q = pin_s2;
    end else begin
      for (int i = 0; i < `PRL_NCELL; i++) begin
        if (cell_edge[i]) begin
          next_q[i] = sync_set_term ? 1'b1 : sop_in[i];
        end
      end
    end
    cell_val = (bypass & sop_in) | (~bypass & q);
    // polarity sits after the flop, so set and clear never see it
    next_pins.out = ~(cell_val ^ polarity);
    // pins released while the tester drives preload values
    next_pins.oe = preload_mode ? 12'h000 : oe_term;
  end

  always_ff @(posedge clock or negedge mc_clear_n) begin
    if (!mc_clear_n) begin
      q <= 12'h000;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence por_window_s;
    state == prl_pkg::PRL_POR;
  endsequence

  sequence run_reached_s;
    state == prl_pkg::PRL_RUN;
  endsequence

  por_clears_regs_a: assert property (@(posedge clock) disable iff (!resetn)
    por_window_s |=> q == 12'h000)
    else $error("macrocell register not clear during power-up");

  por_time_bound_a: assert property (@(posedge clock) disable iff (!resetn)
    por_window_s and ($rose(state == prl_pkg::PRL_POR) || por_cnt == 8'h00) |-> ##[1:200] run_reached_s)
    else $error("power-up register reset took too long");

  pin_level_init_a: assert property (@(posedge clock) disable iff (!mc_clear_n)
    $rose(state == prl_pkg::PRL_RUN) && $stable(polarity) && $stable(bypass)
      |-> ((pins.out ^ ~polarity) & ~bypass) == 12'h000)
    else $error("pin level after power-up ignores polarity");

  preload_loads_pins_a: assert property (@(posedge clock) disable iff (!mc_clear_n)
    preload_hit && ready |=> q == $past(pin_s2))
    else $error("preload did not load pin values");

  locked_readback_a: assert property (@(posedge clock) disable iff (!resetn)
    bus.rd && secure && bus.addr == `PRL_ADDR_PAT_DATA |=> rdata == `PRL_DISCONNECTED)
    else $error("pattern readable while locked");

  locked_no_preload_a: assert property (@(posedge clock) disable iff (!resetn)
    secure |-> !preload_hit ##1 (!preload_mode || !secure))
    else $error("preload possible while locked");

  lock_sticky_a: assert property (@(posedge clock) disable iff (!resetn)
    secure && !erase_hit |=> secure)
    else $error("security bit cleared without erase");

  erase_wipes_a: assert property (@(posedge clock) disable iff (!resetn)
    erase_hit |=> !secure && pattern[0] == `PRL_PAT_RESET && polarity == `PRL_POL_RESET)
    else $error("erase left lock or pattern behind");

  async_clear_low_a: assert property (@(posedge clock) disable iff (!resetn)
    async_clear_term |-> q == 12'h000)
    else $error("clear term did not force registers low");

  sync_set_high_a: assert property (@(posedge clock) disable iff (!mc_clear_n)
    ready && cell_edge[0] && sync_set_term && !preload_hit |=> q[0])
    else $error("set term did not load high");

  capture_edge_a: assert property (@(posedge clock) disable iff (!mc_clear_n)
    ready && cell_edge[0] && !sync_set_term && !preload_hit |=> q[0] == $past(sop_in[0]))
    else $error("flop missed sum term on selected edge");

  lock_forces_mode_a: assert property (@(posedge clock) disable iff (!resetn)
    secure |-> !preload_mode)
    else $error("preload mode active while locked");

  locked_config_read_a: assert property (@(posedge clock) disable iff (!resetn)
    bus.rd && secure && (bus.addr inside {`PRL_ADDR_POLARITY, `PRL_ADDR_CLKSEL, `PRL_ADDR_BYPASS}) |=> rdata == `PRL_DISCONNECTED)
    else $error("configuration readable while locked");

  preload_release_a: assert property (@(posedge clock) disable iff (!resetn)
    preload_mode |=> pins.oe == 12'h000)
    else $error("pins still driven during preload");

  pin_polarity_a: assert property (@(posedge clock) disable iff (!resetn)
    1'b1 |=> pins.out == ~($past(cell_val) ^ $past(polarity)))
    else $error("pin level does not follow cell polarity");

endmodule

// *** prl_defs.svh ***
// constants of the register init and lock block: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the design file
`ifndef PRL_DEFS_SVH
`define PRL_DEFS_SVH

`define PRL_NCELL 12
`define PRL_DW 16
`define PRL_AW 3
`define PRL_PAT_DEPTH 8
`define PRL_PAT_IW 3

// register offsets (word index on the plain port)
`define PRL_ADDR_CTRL 3'h0
`define PRL_ADDR_STATUS 3'h1
`define PRL_ADDR_STATE 3'h2
`define PRL_ADDR_POLARITY 3'h3
`define PRL_ADDR_CLKSEL 3'h4
`define PRL_ADDR_BYPASS 3'h5
`define PRL_ADDR_PAT_INDEX 3'h6
`define PRL_ADDR_PAT_DATA 3'h7

// control bits
`define PRL_CTRL_PRELOAD_MODE 0
`define PRL_CTRL_SECURE 1
`define PRL_CTRL_ERASE 2
`define PRL_CTRL_PRELOAD_GO 3

// status bits
`define PRL_STAT_READY 0
`define PRL_STAT_SECURE 1
`define PRL_STAT_PRELOAD_MODE 2

// unconfigured values restored by reset and erase, and the locked readback value
`define PRL_POL_RESET 12'hFFF
`define PRL_CLKSEL_RESET 12'hFFF
`define PRL_BYPASS_RESET 12'h000
`define PRL_PAT_RESET 16'h0000
`define PRL_DISCONNECTED 16'hFFFF

// power-up register reset time
`define PRL_PUR_TIME_NS 1000
`define PRL_CLK_MHZ 200
`define PRL_PUR_CYCLES ((`PRL_PUR_TIME_NS * `PRL_CLK_MHZ) / 1000)

`endif

// *** prl_pkg.sv ***
// types of the register init and lock block
// assumes prl_defs.svh is on the include path
`include "prl_defs.svh"

package prl_pkg;

  // one register port access
  typedef struct packed {
    logic [`PRL_AW-1:0] addr;
    logic [`PRL_DW-1:0] wdata;
    logic wr;
    logic rd;
  } prl_bus_t;

  // drive of the twelve macrocell pins
  typedef struct packed {
    logic [`PRL_NCELL-1:0] out;
    logic [`PRL_NCELL-1:0] oe;
  } prl_pins_t;

  typedef enum logic [1:0] {
    PRL_POR = 2'h1,
    PRL_RUN = 2'h2
  } prl_state_t;

endpackage

// *** prl_prog.sv ***
// tester model standing on the macrocell pins: resolves each pin level
// assumes pins come from prl_core and drv_en/drv_val come from the bench
`timescale 1ns/1ps
`include "prl_defs.svh"

module prl_prog (
  // clock
  input wire logic clock,
  // device side
  input wire prl_pkg::prl_pins_t pins,
  output logic [`PRL_NCELL-1:0] pin_in,
  // tester drive
  input wire logic drv_en,
  input wire logic [`PRL_NCELL-1:0] drv_val
);
  logic [`PRL_NCELL-1:0] last = '0;

  ////////////////////////////////////////////////////////////////
  // undriven pins flip each cycle so a stale level never looks valid
  always_ff @(posedge clock) begin
    last <= pin_in;
  end

  // tester may force any pattern, illegal states too, once the device lets go
  always_comb begin
    for (int i = 0; i < `PRL_NCELL; i++) begin
      pin_in[i] = pins.oe[i] ? pins.out[i] : (drv_en ? drv_val[i] : ~last[i]);
    end
  end
endmodule

// *** tb_top.sv ***
// self-checking bench for prl_core over its register port and pins
// assumes prl_pkg and prl_defs.svh are compiled first
`timescale 1ns/1ps
`include "prl_defs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end

module tb_top;
  logic clock;
  logic resetn;
  prl_pkg::prl_bus_t bus;
  logic [`PRL_DW-1:0] rdata;
  logic [`PRL_NCELL-1:0] sop_in, oe_term, pin_in, drv_val;
  logic sync_set_term, async_clear_term, clk_a_pin, clk_b_pin, ready, drv_en;
  prl_pkg::prl_pins_t pins;
  int fails = 0;
  int cmp_count = 0;
  int n;

  prl_core i_prl_core (.clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata), .sop_in(sop_in),
    .oe_term(oe_term), .sync_set_term(sync_set_term), .async_clear_term(async_clear_term),
    .clk_a_pin(clk_a_pin), .clk_b_pin(clk_b_pin), .pin_in(pin_in), .pins(pins), .ready(ready));
  prl_prog i_prl_prog (.clock(clock), .pins(pins), .pin_in(pin_in), .drv_en(drv_en), .drv_val(drv_val));

  ////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic wr(input logic [`PRL_AW-1:0] a, input logic [`PRL_DW-1:0] d);
    @(posedge clock);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [`PRL_AW-1:0] a, input logic [`PRL_DW-1:0] e, input string nm);
    @(posedge clock);
    bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask

  // pin held two cycles so the synchroniser sees one clean rise
  task automatic pulse(input logic a, input logic b);
    @(posedge clock);
    clk_a_pin <= a;
    clk_b_pin <= b;
    repeat (2) @(posedge clock);
    clk_a_pin <= 1'b0;
    clk_b_pin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    wrap_up;
  end

  initial begin
    resetn = 1'b0;
    bus = '0;
    sop_in = '0;
    oe_term = 12'hFFF;
    sync_set_term = 1'b0;
    async_clear_term = 1'b0;
    clk_a_pin = 1'b0;
    clk_b_pin = 1'b0;
    drv_en = 1'b0;
    drv_val = '0;
    repeat (8) @(posedge clock);
    `CHK("ready", 1'b0, ready)
    resetn <= 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK("por cycles", 200, n)
    rc(`PRL_ADDR_STATE, 16'h0000, "state");
    `CHK("out", 12'h000, pins.out)
    `CHK("oe", 12'hFFF, pins.oe)
    wr(`PRL_ADDR_POLARITY, 16'h000F);
    repeat (2) @(posedge clock);
    `CHK("out", 12'hFF0, pins.out)
    wr(`PRL_ADDR_BYPASS, 16'h0003);
    sop_in <= 12'h001;
    repeat (3) @(posedge clock);
    `CHK("out", 12'hFF1, pins.out)
    wr(`PRL_ADDR_BYPASS, 16'h0000);
    sop_in <= 12'hABC;
    pulse(1'b1, 1'b0);
    rc(`PRL_ADDR_STATE, 16'h0ABC, "state");
    wr(`PRL_ADDR_CLKSEL, 16'h0F0F);
    sop_in <= 12'h555;
    pulse(1'b1, 1'b0);
    rc(`PRL_ADDR_STATE, 16'h05B5, "state");
    sync_set_term <= 1'b1;
    pulse(1'b1, 1'b1);
    sync_set_term <= 1'b0;
    rc(`PRL_ADDR_STATE, 16'h0FFF, "state");
    async_clear_term <= 1'b1;
    @(posedge clock);
    async_clear_term <= 1'b0;
    rc(`PRL_ADDR_STATE, 16'h0000, "state");
    // preload of a pattern no sum term produced
    wr(`PRL_ADDR_CTRL, 16'h0001);
    drv_en <= 1'b1;
    drv_val <= 12'hA5A;
    repeat (3) @(posedge clock);
    `CHK("oe", 12'h000, pins.oe)
    wr(`PRL_ADDR_CTRL, 16'h0009);
    rc(`PRL_ADDR_STATE, 16'h0A5A, "state");
    wr(`PRL_ADDR_CTRL, 16'h0000);
    drv_en <= 1'b0;
    wr(`PRL_ADDR_PAT_INDEX, 16'h0002);
    wr(`PRL_ADDR_PAT_DATA, 16'h1234);
    rc(`PRL_ADDR_PAT_DATA, 16'h1234, "pattern");
    wr(`PRL_ADDR_CTRL, 16'h0002);
    rc(`PRL_ADDR_PAT_DATA, 16'hFFFF, "pattern");
    rc(`PRL_ADDR_POLARITY, 16'hFFFF, "polarity");
    wr(`PRL_ADDR_CTRL, 16'h0001);
    rc(`PRL_ADDR_STATUS, 16'h0003, "status");
    drv_en <= 1'b1;
    drv_val <= 12'h0F0;
    wr(`PRL_ADDR_CTRL, 16'h0009);
    rc(`PRL_ADDR_STATE, 16'h0A5A, "state");
    drv_en <= 1'b0;
    wr(`PRL_ADDR_POLARITY, 16'h0000);
    repeat (2) @(posedge clock);
    `CHK("out", 12'h5AA, pins.out)
    wr(`PRL_ADDR_CTRL, 16'h0004);
    rc(`PRL_ADDR_STATUS, 16'h0001, "status");
    wr(`PRL_ADDR_PAT_INDEX, 16'h0002);
    rc(`PRL_ADDR_PAT_DATA, 16'h0000, "pattern");
    rc(`PRL_ADDR_POLARITY, 16'h0FFF, "polarity");
    wrap_up;
  end
endmodule
